// ==== src/t1_ctrl_params.svh ====
`ifndef T1_CTRL_PARAMS_SVH
`define T1_CTRL_PARAMS_SVH

// Register offsets on the first page
`define T1C_ADDR_RESERVED 8'h16
`define T1C_ADDR_SLIP_DELAY 8'h17
`define T1C_ADDR_TX_MESSAGE 8'h18
`define T1C_ADDR_ERR_INJECT 8'h19
`define T1C_ADDR_RESET_CTRL 8'h1a

// Error injection control field positions
`define T1C_BIT_BPV_INJECT 7
`define T1C_BIT_CRC6_INJECT 6
`define T1C_BIT_FT_INJECT 5
`define T1C_BIT_FS_INJECT 4
`define T1C_BIT_FORCE_NO_PULSES 3
`define T1C_BIT_PAYLOAD_INJECT 2
`define T1C_BIT_LOSS_SRC_SEL 0

// Reset and interrupt control field positions
`define T1C_BIT_SOFT_RESET 7
`define T1C_BIT_SUSPEND 6
`define T1C_BIT_INT_ACK 5
`define T1C_BIT_COUNTER_CLEAR 4
`define T1C_BIT_SAMPLE 3
`define T1C_BIT_EXT_OSC 2

// Writable masks (injection bit 1 and the acknowledge bit read as zero)
`define T1C_ERR_INJECT_MASK 8'hfd
`define T1C_RESET_CTRL_MASK 8'hdf

// Reset values
`define T1C_RST_SLIP_DELAY 8'h00
`define T1C_RST_TX_MESSAGE 8'h00
`define T1C_RST_ERR_INJECT 8'h00
`define T1C_RST_RESET_CTRL 8'h00

// Timing
`define T1C_CLK_PERIOD_NS 20
`define T1C_FRAME_PERIOD_NS 125000
`define T1C_SOFT_RESET_CYCLES 4
`define T1C_DELAY_STEP_CYCLES 24

`endif

// ==== src/t1_ctrl_pkg.sv ====
package t1_ctrl_pkg;

    typedef enum logic [1:0] {
        SRST_IDLE,
        SRST_ACTIVE,
        SRST_DONE
    } soft_reset_state_type;

    typedef logic [7:0] reg_byte_type;

endpackage

// ==== src/inject_edge_detect.sv ====
`timescale 1ns/100ps
`default_nettype none

// Compares newly written bits with their stored copy and emits a
// one-cycle request for each bit that goes from zero to one.
module inject_edge_detect #(
    parameter int WIDTH = 5
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_write,
    input wire logic [WIDTH-1:0] i_new_bits,
    input wire logic [WIDTH-1:0] i_old_bits,
    output logic [WIDTH-1:0] o_pulse
);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pulse <= '0;
        end else if (i_clear) begin
            o_pulse <= '0;
        end else if (i_write) begin
            o_pulse <= i_new_bits & ~i_old_bits;
        end else begin
            o_pulse <= '0;
        end
    end

endmodule

`default_nettype wire

// ==== src/t1_tx_error_insert_reset_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

`include "t1_ctrl_params.svh"

// Function
// - Slip delay register write applies the transmit buffer delay once only.
// - Delay is set by moving the generated line frame boundary.
// - Applied delay always stays shorter than one line frame.
// - Message byte goes out in channels selected for message insertion.
// - Rising bipolar violation bit inserts one bipolar violation.
// - Rising terminal framing bit inserts one framing pattern error.
// - Rising signaling framing bit inserts one error, D4 only.
// - Steady levels and falling edges of injection bits do nothing.
// - Force-no-pulses bit sends all zeros, overriding zero suppression.
// - Rising payload bit flips exactly one transmitted payload bit.
// - Loss pin shows signal loss only, or signal or frame loss.
// - Software reset acts as hardware reset, then clears itself.
// - Suspend floats the interrupt output and ignores interrupts.
// - Acknowledge clears interrupt status, floats output, self-clears.
// - Counter clear holds every error counter at zero.
// - Sample bit limits counter updates to the one-second tick.
// - External oscillator select makes oscillator pin a logic input.
module t1_tx_error_insert_reset_ctrl
    import t1_ctrl_pkg::*;
#(
    parameter int FRAME_CYCLES =
        `T1C_FRAME_PERIOD_NS / `T1C_CLK_PERIOD_NS,
    parameter int DELAY_STEP_CYCLES = `T1C_DELAY_STEP_CYCLES,
    parameter int SOFT_RESET_CYCLES = `T1C_SOFT_RESET_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Parallel microprocessor port
    input wire logic i_cs_n,
    input wire logic i_ds_n,
    input wire logic i_rw_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    // Transmit path
    input wire logic i_msg_channel_sel,
    input wire logic [7:0] i_tx_channel_data,
    output t1_ctrl_pkg::reg_byte_type o_tx_channel_data,
    output logic [7:0] o_tx_slip_delay_value,
    output logic o_tx_frame_boundary,
    output logic o_bipolar_violation_inject,
    output logic o_crc6_error_inject,
    output logic o_terminal_framing_error_inject,
    output logic o_signaling_framing_error_inject,
    output logic o_payload_bit_error_inject,
    output logic o_force_no_pulses,
    // Loss indication
    input wire logic i_line_loss_status,
    input wire logic i_frame_loss_status,
    output logic o_loss_indication_pin,
    // Interrupt request, open drain, active low
    input wire logic i_irq_request,
    output logic o_irq_out,
    output logic o_irq_oe,
    output logic o_int_status_clear,
    // Counters
    input wire logic i_one_second_tick,
    output logic o_counter_clear,
    output logic o_counter_update_en,
    // Oscillator and reset
    output logic o_external_oscillator_select,
    output logic o_soft_reset
);

    import t1_ctrl_pkg::*;

    localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);
    localparam logic [15:0] STEP = 16'(DELAY_STEP_CYCLES);
    localparam logic [3:0] SRST_LAST = 4'(SOFT_RESET_CYCLES - 1);

    // Two-flop synchronisers for the microprocessor port and loss status inputs
    logic [19:0] pin_meta_r;
    logic [19:0] pin_sync_r;
    logic [1:0] loss_meta_r;
    logic [1:0] loss_sync_r;

    logic access_prev_r;
    logic access_now;
    logic access_start;
    logic wr_strobe;
    logic rd_strobe;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;

    reg_byte_type slip_delay_r;
    reg_byte_type tx_message_r;
    reg_byte_type err_inject_r;
    reg_byte_type reset_ctrl_r;

    soft_reset_state_type srst_state_r;
    soft_reset_state_type srst_state_nxt;
    logic [3:0] srst_count_r;
    logic soft_clear;

    logic wr_slip;
    logic wr_message;
    logic wr_inject;
    logic wr_reset;
    logic [4:0] inject_pulse;
    logic [4:0] inject_old;
    logic [4:0] inject_new;

    logic [15:0] frame_count_r;
    logic [15:0] delay_cycles;

    logic int_ack_r;
    logic [7:0] read_value;

    function automatic logic [15:0] clamp_delay(input logic [7:0] value);
        logic [15:0] cycles;
        cycles = 16'(value) * STEP;
        if (cycles > FRAME_LAST) begin
            clamp_delay = FRAME_LAST;
        end else begin
            clamp_delay = cycles;
        end
    endfunction

    function automatic logic [4:0] inject_bits(input logic [7:0] value);
        inject_bits = {value[`T1C_BIT_BPV_INJECT],
                       value[`T1C_BIT_CRC6_INJECT],
                       value[`T1C_BIT_FT_INJECT],
                       value[`T1C_BIT_FS_INJECT],
                       value[`T1C_BIT_PAYLOAD_INJECT]};
    endfunction

    // Pin synchronisers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_meta_r <= 20'h0_000e;
            pin_sync_r <= 20'h0_000e;
        end else begin
            pin_meta_r <= {i_addr, i_data, i_cs_n, i_ds_n, i_rw_n, 1'b0};
            pin_sync_r <= pin_meta_r;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            loss_meta_r <= 2'h0;
            loss_sync_r <= 2'h0;
        end else begin
            loss_meta_r <= {i_line_loss_status, i_frame_loss_status};
            loss_sync_r <= loss_meta_r;
        end
    end

    assign bus_addr = pin_sync_r[19:12];
    assign bus_wdata = pin_sync_r[11:4];
    assign access_now = !pin_sync_r[3] && !pin_sync_r[2];
    assign access_start = access_now && !access_prev_r;
    assign wr_strobe = access_start && !pin_sync_r[1];
    assign rd_strobe = access_now && pin_sync_r[1];

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            access_prev_r <= 1'b0;
        end else begin
            access_prev_r <= access_now;
        end
    end

    // Address decode for writes
    always_comb begin
        wr_slip = 1'b0;
        wr_message = 1'b0;
        wr_inject = 1'b0;
        wr_reset = 1'b0;
        if (!wr_strobe) begin
            wr_slip = 1'b0;
        end else if (bus_addr == `T1C_ADDR_SLIP_DELAY) begin
            wr_slip = 1'b1;
        end else if (bus_addr == `T1C_ADDR_TX_MESSAGE) begin
            wr_message = 1'b1;
        end else if (bus_addr == `T1C_ADDR_ERR_INJECT) begin
            wr_inject = 1'b1;
        end else if (bus_addr == `T1C_ADDR_RESET_CTRL) begin
            wr_reset = 1'b1;
        end
    end

    // Software reset sequencer
    always_comb begin
        srst_state_nxt = srst_state_r;
        case (srst_state_r)
            SRST_IDLE: begin
                if (wr_reset && bus_wdata[`T1C_BIT_SOFT_RESET]) begin
                    srst_state_nxt = SRST_ACTIVE;
                end
            end
            SRST_ACTIVE: begin
                if (srst_count_r == SRST_LAST) begin
                    srst_state_nxt = SRST_DONE;
                end
            end
            SRST_DONE: begin
                srst_state_nxt = SRST_IDLE;
            end
            default: begin
                srst_state_nxt = SRST_IDLE;
            end
        endcase
    end

    assign soft_clear = (srst_state_r == SRST_ACTIVE);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            srst_state_r <= SRST_IDLE;
            srst_count_r <= 4'h0;
        end else begin
            srst_state_r <= srst_state_nxt;
            if (srst_state_r == SRST_ACTIVE) begin
                srst_count_r <= srst_count_r + 4'h1;
            end else begin
                srst_count_r <= 4'h0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_soft_reset <= 1'b0;
        end else begin
            o_soft_reset <= (srst_state_nxt == SRST_ACTIVE);
        end
    end

    // Control registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slip_delay_r <= `T1C_RST_SLIP_DELAY;
            tx_message_r <= `T1C_RST_TX_MESSAGE;
        end else if (soft_clear) begin
            slip_delay_r <= `T1C_RST_SLIP_DELAY;
            tx_message_r <= `T1C_RST_TX_MESSAGE;
        end else begin
            if (wr_slip) begin
                slip_delay_r <= bus_wdata;
            end
            if (wr_message) begin
                tx_message_r <= bus_wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_inject_r <= `T1C_RST_ERR_INJECT;
        end else if (soft_clear) begin
            err_inject_r <= `T1C_RST_ERR_INJECT;
        end else if (wr_inject) begin
            err_inject_r <= bus_wdata & `T1C_ERR_INJECT_MASK;
        end
    end

    // Reset control; acknowledge is kept apart as it clears itself
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reset_ctrl_r <= `T1C_RST_RESET_CTRL;
        end else if (soft_clear) begin
            reset_ctrl_r <= `T1C_RST_RESET_CTRL;
        end else if (wr_reset) begin
            reset_ctrl_r <= bus_wdata & `T1C_RESET_CTRL_MASK;
            reset_ctrl_r[`T1C_BIT_SOFT_RESET] <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_ack_r <= 1'b0;
        end else begin
            int_ack_r <= wr_reset && bus_wdata[`T1C_BIT_INT_ACK]
                && !soft_clear;
        end
    end

    // Injection edge detection against the stored bits
    assign inject_old = inject_bits(err_inject_r);
    assign inject_new = inject_bits(bus_wdata);

    inject_edge_detect #(
        .WIDTH(5)
    ) u_inject_edge (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_clear(soft_clear),
        .i_write(wr_inject),
        .i_new_bits(inject_new),
        .i_old_bits(inject_old),
        .o_pulse(inject_pulse)
    );

    assign o_bipolar_violation_inject = inject_pulse[4];
    assign o_crc6_error_inject = inject_pulse[3];
    assign o_terminal_framing_error_inject = inject_pulse[2];
    assign o_signaling_framing_error_inject = inject_pulse[1];
    assign o_payload_bit_error_inject = inject_pulse[0];

    // Line frame boundary generator; a delay write shifts it once
    assign delay_cycles = clamp_delay(bus_wdata);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame_count_r <= 16'h0000;
            o_tx_frame_boundary <= 1'b0;
        end else if (wr_slip) begin
            frame_count_r <= FRAME_LAST - delay_cycles;
            o_tx_frame_boundary <= 1'b0;
        end else if (frame_count_r >= FRAME_LAST) begin
            frame_count_r <= 16'h0000;
            o_tx_frame_boundary <= 1'b1;
        end else begin
            frame_count_r <= frame_count_r + 16'h0001;
            o_tx_frame_boundary <= 1'b0;
        end
    end

    // Transmit data path controls
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_channel_data <= 8'h00;
            o_tx_slip_delay_value <= 8'h00;
            o_force_no_pulses <= 1'b0;
        end else begin
            if (o_force_no_pulses) begin
                o_tx_channel_data <= 8'h00;
            end else if (i_msg_channel_sel) begin
                o_tx_channel_data <= tx_message_r;
            end else begin
                o_tx_channel_data <= i_tx_channel_data;
            end
            o_tx_slip_delay_value <= slip_delay_r;
            o_force_no_pulses <=
                err_inject_r[`T1C_BIT_FORCE_NO_PULSES];
        end
    end

    // Loss indication pin source
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_loss_indication_pin <= 1'b0;
        end else if (err_inject_r[`T1C_BIT_LOSS_SRC_SEL]) begin
            o_loss_indication_pin <= loss_sync_r[1];
        end else begin
            o_loss_indication_pin <= loss_sync_r[1] || loss_sync_r[0];
        end
    end

    // Interrupt output: pulled low only while a request is pending
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_out <= 1'b0;
            o_irq_oe <= 1'b0;
            o_int_status_clear <= 1'b0;
        end else begin
            o_irq_out <= 1'b0;
            o_int_status_clear <= int_ack_r || soft_clear;
            if (reset_ctrl_r[`T1C_BIT_SUSPEND] || soft_clear) begin
                o_irq_oe <= 1'b0;
            end else if (int_ack_r) begin
                o_irq_oe <= 1'b0;
            end else begin
                o_irq_oe <= i_irq_request;
            end
        end
    end

    // Counter control and oscillator select
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_counter_clear <= 1'b0;
            o_counter_update_en <= 1'b1;
            o_external_oscillator_select <= 1'b0;
        end else begin
            o_counter_clear <= reset_ctrl_r[`T1C_BIT_COUNTER_CLEAR]
                || soft_clear;
            o_counter_update_en <= !reset_ctrl_r[`T1C_BIT_SAMPLE]
                || i_one_second_tick;
            o_external_oscillator_select <=
                reset_ctrl_r[`T1C_BIT_EXT_OSC];
        end
    end

    // Read decode; addresses outside this block leave the bus alone
    always_comb begin
        read_value = 8'h00;
        if (bus_addr == `T1C_ADDR_RESERVED) begin
            read_value = 8'h00;
        end else if (bus_addr == `T1C_ADDR_SLIP_DELAY) begin
            read_value = slip_delay_r;
        end else if (bus_addr == `T1C_ADDR_TX_MESSAGE) begin
            read_value = tx_message_r;
        end else if (bus_addr == `T1C_ADDR_ERR_INJECT) begin
            read_value = err_inject_r;
        end else if (bus_addr == `T1C_ADDR_RESET_CTRL) begin
            read_value = reset_ctrl_r;
            read_value[`T1C_BIT_SOFT_RESET] = (srst_state_r != SRST_IDLE);
            read_value[`T1C_BIT_INT_ACK] = int_ack_r;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
        end else if (rd_strobe && bus_addr >= `T1C_ADDR_RESERVED
                && bus_addr <= `T1C_ADDR_RESET_CTRL) begin
            o_data <= read_value;
            o_data_oe <= 1'b1;
        end else begin
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ==== verif/t1_ctrl_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module t1_ctrl_props #(
    parameter int SOFT_RESET_CYCLES = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_ds_n,
    input wire logic i_rw_n,
    input wire logic i_line_loss_status,
    input wire logic i_frame_loss_status,
    input wire logic i_one_second_tick,
    input wire t1_ctrl_pkg::reg_byte_type o_tx_channel_data,
    input wire logic o_tx_frame_boundary,
    input wire logic o_bipolar_violation_inject,
    input wire logic o_payload_bit_error_inject,
    input wire logic o_force_no_pulses,
    input wire logic o_loss_indication_pin,
    input wire logic o_irq_oe,
    input wire logic o_int_status_clear,
    input wire logic o_counter_clear,
    input wire logic o_counter_update_en,
    input wire logic o_soft_reset
);
    import t1_ctrl_pkg::*;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    int srst_cnt;
    // Length of the current software reset in cycles
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            srst_cnt <= 0;
        end else begin
            srst_cnt <= o_soft_reset ? srst_cnt + 1 : 0;
        end
    end
    property p_bpv_once;
        o_bipolar_violation_inject |=> !o_bipolar_violation_inject;
    endproperty
    a_bpv_once: assert property (p_bpv_once)
        else $error("violation request longer than one cycle");
    property p_pay_cause;
        o_payload_bit_error_inject |-> $past(!i_cs_n && !i_ds_n && !i_rw_n, 3);
    endproperty
    a_pay_cause: assert property (p_pay_cause)
        else $error("payload request without a write");
    property p_force_zero;
        o_force_no_pulses && $past(o_force_no_pulses) |-> o_tx_channel_data == 8'h00;
    endproperty
    a_force_zero: assert property (p_force_zero)
        else $error("data sent while pulses are forced off");
    property p_loss_los;
        $past(i_line_loss_status, 3) |-> o_loss_indication_pin;
    endproperty
    a_loss_los: assert property (p_loss_los)
        else $error("loss pin low during signal loss");
    property p_loss_none;
        !$past(i_line_loss_status || i_frame_loss_status, 3)
            |-> !o_loss_indication_pin;
    endproperty
    a_loss_none: assert property (p_loss_none)
        else $error("loss pin high without any loss");
    property p_upd_tick;
        $past(i_one_second_tick) |-> o_counter_update_en;
    endproperty
    a_upd_tick: assert property (p_upd_tick)
        else $error("no counter update on the second tick");
    property p_srst_len;
        $fell(o_soft_reset) |-> srst_cnt == SOFT_RESET_CYCLES;
    endproperty
    a_srst_len: assert property (p_srst_len)
        else $error("software reset has the wrong length");
    property p_srst_clr;
        o_soft_reset && $past(o_soft_reset) |-> o_counter_clear && !o_irq_oe;
    endproperty
    a_srst_clr: assert property (p_srst_clr)
        else $error("software reset left counters or request active");
    property p_ack_float;
        o_int_status_clear && !o_soft_reset |-> !o_irq_oe;
    endproperty
    a_ack_float: assert property (p_ack_float)
        else $error("request still driven while status clears");
    c_bpv: cover property (o_bipolar_violation_inject);
    c_srst: cover property ($fell(o_soft_reset));
    c_frame: cover property (o_tx_frame_boundary);
endmodule
`default_nettype wire

// ==== verif/tb_t1_tx_error_insert_reset_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_t1_tx_error_insert_reset_ctrl;
    import t1_ctrl_pkg::*;
    localparam int FRM = 64;
    logic i_sys_clk = 0, i_rst_n = 0, i_cs_n = 1, i_ds_n = 1, i_rw_n = 1;
    logic i_msg_channel_sel = 0, i_line_loss_status = 0;
    logic i_frame_loss_status = 0, i_irq_request = 0, i_one_second_tick = 0;
    logic [7:0] i_addr = 0, i_data = 0, i_tx_channel_data = 0, o_data;
    logic [7:0] o_tx_slip_delay_value, q, m[5];
    reg_byte_type o_tx_channel_data;
    logic o_data_oe, o_tx_frame_boundary, o_force_no_pulses, oe;
    logic o_bipolar_violation_inject, o_crc6_error_inject;
    logic o_terminal_framing_error_inject, o_signaling_framing_error_inject;
    logic o_payload_bit_error_inject, o_loss_indication_pin, o_irq_out;
    logic o_irq_oe, o_int_status_clear, o_counter_clear, o_counter_update_en;
    logic o_external_oscillator_select, o_soft_reset;
    int num_errors, num_checks, cyc, nclr, t_wr, np[5];
    int bq[$];
    logic [31:0] seed = 89;
    t1_tx_error_insert_reset_ctrl #(
        .FRAME_CYCLES(FRM), .DELAY_STEP_CYCLES(1)
    ) dut_u (
        .i_sys_clk, .i_rst_n, .i_cs_n, .i_ds_n, .i_rw_n, .i_addr, .i_data,
        .o_data, .o_data_oe, .i_msg_channel_sel, .i_tx_channel_data,
        .o_tx_channel_data, .o_tx_slip_delay_value, .o_tx_frame_boundary,
        .o_bipolar_violation_inject, .o_crc6_error_inject,
        .o_terminal_framing_error_inject, .o_signaling_framing_error_inject,
        .o_payload_bit_error_inject, .o_force_no_pulses, .i_line_loss_status,
        .i_frame_loss_status, .o_loss_indication_pin, .i_irq_request,
        .o_irq_out, .o_irq_oe, .o_int_status_clear, .i_one_second_tick,
        .o_counter_clear, .o_counter_update_en, .o_external_oscillator_select,
        .o_soft_reset
    );
    wire logic [4:0] inj = {o_bipolar_violation_inject, o_crc6_error_inject,
        o_terminal_framing_error_inject, o_signaling_framing_error_inject,
        o_payload_bit_error_inject};
    task automatic complete_run();
        if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #2;
    endtask
    // One strobe held across the synchroniser latency, then a quiet gap
    task automatic acc(input logic rw, input logic [7:0] a, input logic [7:0] d);
        tick(1);
        {i_cs_n, i_ds_n, i_rw_n, i_addr, i_data} = {2'b00, rw, a, d};
        t_wr = cyc;
        repeat (4) @(posedge i_sys_clk);
        #2;
        q = o_data;
        oe = o_data_oe;
        {i_cs_n, i_ds_n, i_rw_n} = 3'b111;
        tick(4);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] mk[5];
        mk = '{8'h00, 8'hff, 8'hff, 8'hfd, 8'h5f};
        acc(1'b0, a, d);
        if (a == 8'h1a && d[7]) m = '{default: 8'h00};
        else if (a inside {[8'h16:8'h1a]}) m[a - 8'h16] = d & mk[a - 8'h16];
    endtask
    task automatic rdc(input logic [7:0] a);
        logic ok;
        ok = a inside {[8'h16:8'h1a]};
        acc(1'b1, a, 8'h00);
        chk(8'(oe), 8'(ok));
        chk(q, ok ? m[a - 8'h16] : 8'h00);
    endtask
    always #10 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc++;
        for (int k = 0; k < 5; k++) np[k] += int'(inj[k] === 1'b1);
        nclr += int'(o_int_status_clear === 1'b1);
        if (o_tx_frame_boundary === 1'b1) bq.push_back(cyc);
        if (cyc == 30000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        int b, n0[5], d[3];
        logic [7:0] e;
        m = '{default: 8'h00};
        tick(10);
        i_rst_n = 1;
        for (int a = 8'h16; a <= 8'h1a; a++) rdc(8'(a));
        rdc(8'h20);
        for (int a = 8'h16; a <= 8'h18; a++) begin
            wr(8'(a), rnd() | 8'h01);
            rdc(8'(a));
        end
        i_msg_channel_sel = 1;
        i_tx_channel_data = rnd();
        tick(2);
        chk(o_tx_channel_data, m[2]);
        i_msg_channel_sel = 0;
        tick(2);
        chk(o_tx_channel_data, i_tx_channel_data);
        wr(8'h19, 8'h08);
        chk(o_tx_channel_data, 8'h00);
        chk(8'(o_force_no_pulses), 8'h01);
        rdc(8'h19);
        // Each injection bit alone, then all together
        for (int k = 0; k < 6; k++) begin
            e = (k == 5) ? 8'hf4 : (k == 0) ? 8'h04 : 8'h01 << (k + 3);
            wr(8'h19, 8'h00);
            n0 = np;
            wr(8'h19, e);
            wr(8'h19, e);
            wr(8'h19, 8'h00);
            for (int j = 0; j < 5; j++) begin
                chk(8'(np[j] - n0[j]), 8'(k == j || k == 5));
                chk(8'(np[j] - n0[j]), 8'(k == j || k == 5));
            end
        end
        for (int c = 0; c < 8; c++) begin
            if (c % 4 == 0) wr(8'h19, 8'(c / 4));
            {i_line_loss_status, i_frame_loss_status} = 2'(c);
            tick(4);
            chk(8'(o_loss_indication_pin), 8'(c[1] | (c < 4 && c[0])));
        end
        {i_line_loss_status, i_frame_loss_status} = 2'b00;
        for (int k = 0; k < 3; k++) begin
            wr(8'h17, k == 0 ? 8'd5 : k == 1 ? 8'd20 : 8'd200);
            b = t_wr;
            tick(140);
            while (bq.size() > 0 && bq[0] <= b + 4) void'(bq.pop_front());
            d[k] = bq[0] - b;
            chk(8'(bq[1] - bq[0]), 8'(FRM));
            chk(o_tx_slip_delay_value, m[1]);
        end
        chk(8'(d[1] - d[0]), 8'd15);
        chk(8'(d[2] - d[1]), 8'(FRM - 21));
        b = bq[$];
        wr(8'h18, rnd());
        tick(140);
        chk(8'((bq[$] - b) % FRM), 8'h00);
        i_irq_request = 1;
        tick(3);
        chk(8'(o_irq_oe), 8'h01);
        chk(8'(o_irq_out), 8'h00);
        b = nclr;
        wr(8'h1a, 8'h20);
        chk(8'(nclr - b), 8'h01);
        rdc(8'h1a);
        wr(8'h1a, 8'h40);
        chk(8'(o_irq_oe), 8'h00);
        wr(8'h1a, 8'h10);
        chk(8'(o_irq_oe), 8'h01);
        chk(8'(o_counter_clear), 8'h01);
        wr(8'h1a, 8'h0c);
        chk(8'(o_external_oscillator_select), 8'h01);
        chk(8'(o_counter_update_en), 8'h00);
        i_one_second_tick = 1;
        tick(1);
        i_one_second_tick = 0;
        chk(8'(o_counter_update_en), 8'h01);
        tick(1);
        chk(8'(o_counter_update_en), 8'h00);
        rdc(8'h1a);
        wr(8'h1a, 8'h8c);
        chk(8'(o_soft_reset), 8'h00);
        chk(8'(o_external_oscillator_select), 8'h00);
        for (int a = 8'h16; a <= 8'h1a; a++) rdc(8'(a));
        complete_run();
    end
endmodule
bind t1_tx_error_insert_reset_ctrl t1_ctrl_props #(
    .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)
) props_u (
    .i_sys_clk, .i_rst_n, .i_cs_n, .i_ds_n, .i_rw_n, .i_line_loss_status,
    .i_frame_loss_status, .i_one_second_tick, .o_tx_channel_data,
    .o_tx_frame_boundary, .o_bipolar_violation_inject,
    .o_payload_bit_error_inject, .o_force_no_pulses, .o_loss_indication_pin,
    .o_irq_oe, .o_int_status_clear, .o_counter_clear, .o_counter_update_en,
    .o_soft_reset
);
`default_nettype wire
